// File: encoder_od_pkg.sv
// shared constants for the encoder diagnostic object dictionary slice
package encoder_od_pkg;

	// object dictionary indices
	localparam logic [15:0] IDX_OPERATING_TIME = 16'h6508;
	localparam logic [15:0] IDX_PRESET_OFFSET_VALUE = 16'h6509;
	localparam logic [15:0] IDX_MODULE_POSITION_LIMITS = 16'h650A;
	localparam logic [15:0] IDX_SERIAL_NUMBER = 16'h650B;
	localparam logic [15:0] IDX_IDENTITY = 16'h1018;

	// subindices
	localparam logic [7:0] SUB_ZERO = 8'h00;
	localparam logic [7:0] SUB_MFR_OFFSET = 8'h01;
	localparam logic [7:0] SUB_MFR_MIN = 8'h02;
	localparam logic [7:0] SUB_MFR_MAX = 8'h03;
	localparam logic [7:0] SUB_IDENTITY_SERIAL = 8'h04;

	// fixed and reset values
	localparam logic [31:0] OPERATING_TIME_VALUE = 32'h0FFF_FFFF;
	localparam logic [31:0] MODULE_HIGHEST_SUB = 32'h0000_0003;
	localparam logic [31:0] PRESET_OFFSET_RESET = 32'h0000_0000;
	localparam logic [6:0] NODE_NUMBER_RESET = 7'h00;
	localparam logic [3:0] BAUD_SEL_RESET = 4'h0;

	// access abort codes returned with a refused request
	localparam logic [31:0] ABORT_WRITE_READ_ONLY = 32'h0601_0002;
	localparam logic [31:0] ABORT_READ_WRITE_ONLY = 32'h0601_0001;
	localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
	localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h0609_0011;
	localparam logic [31:0] ABORT_NONE = 32'h0000_0000;

	// function codes used to build identifiers
	localparam logic [3:0] FC_BOOTUP = 4'hE;
	localparam logic [3:0] FC_SDO_TX = 4'hB;

	// access classes of an entry
	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_RO,
		ACC_WO,
		ACC_RW
	} access_t;

endpackage

// File: pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage2_next;

	always_comb begin
		stage1_next = pin_in;
		stage2_next = stage1_reg;
	end

	// keeps sampling through reset so the pins are settled when reset ends
	always_ff @(posedge clk_sys) begin
		stage1_reg <= stage1_next;
		stage2_reg <= stage2_next;
	end

	assign pin_out = stage2_reg;

endmodule // pin_sync

// File: settings_latch.sv
// holds node number and baud selection until an apply event
`timescale 1ns/1ps
module settings_latch (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [6:0] node_sel_in,
	input wire logic [3:0] baud_sel_in,
	input wire logic apply,
	output logic [6:0] node_number,
	output logic [3:0] baud_sel,
	output logic applied
);

	logic pend_reg;
	logic pend_next;
	logic [6:0] node_reg;
	logic [6:0] node_next;
	logic [3:0] baud_reg;
	logic [3:0] baud_next;
	logic applied_reg;
	logic applied_next;

	// the pins are taken one cycle after reset release or on apply
	always_comb begin
		pend_next = 1'b0;
		node_next = node_reg;
		baud_next = baud_reg;
		applied_next = 1'b0;
		if (pend_reg || apply) begin
			node_next = node_sel_in;
			baud_next = baud_sel_in;
			applied_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_reg <= 1'b1;
			node_reg <= encoder_od_pkg::NODE_NUMBER_RESET;
			baud_reg <= encoder_od_pkg::BAUD_SEL_RESET;
			applied_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			node_reg <= node_next;
			baud_reg <= baud_next;
			applied_reg <= applied_next;
		end
	end

	assign node_number = node_reg;
	assign baud_sel = baud_reg;
	assign applied = applied_reg;

endmodule // settings_latch

// File: encoder_od_diagnostic_objects.sv
// diagnostic object dictionary entries and node-level boot behaviour
`timescale 1ns/1ps
module encoder_od_diagnostic_objects #(
	// arbitrary neutral serial number
	parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
	parameter logic [31:0] MFR_OFFSET = 32'h0000_0000,
	parameter logic [31:0] MFR_MIN_POSITION = 32'h0000_0000,
	parameter logic [31:0] MFR_MAX_POSITION = 32'h0000_FFFF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sdo_req_valid,
	input wire logic sdo_req_write,
	input wire logic [15:0] sdo_req_index,
	input wire logic [7:0] sdo_req_subindex,
	output logic sdo_rsp_valid,
	output logic [31:0] sdo_rsp_data,
	output logic sdo_rsp_abort,
	output logic [31:0] sdo_rsp_abort_code,
	output logic [10:0] sdo_rsp_cob_id,
	input wire logic preset_offset_load,
	input wire logic [31:0] preset_offset_in,
	input wire logic [6:0] node_switch_pins,
	input wire logic [3:0] baud_switch_pins,
	input wire logic nmt_reset_cmd,
	input wire logic store_params_cmd,
	input wire logic bus_rate_ok,
	output logic bootup_tx_req,
	output logic [10:0] bootup_cob_id,
	input wire logic bootup_tx_ack,
	input wire logic limit_enable_cmd,
	input wire logic [1:0] limit_bits_in,
	output logic [1:0] limit_bits_out,
	output logic [6:0] node_number,
	output logic [3:0] baud_sel
);

	typedef enum {
		BOOT_INIT,
		BOOT_WAIT_RATE,
		BOOT_SEND,
		BOOT_RUN
	} boot_state_t;

	// identifier from function code and node; lower value wins arbitration
	function automatic logic [10:0] cob_id(input logic [3:0] fc, input logic [6:0] node);
		cob_id = {fc, node};
	endfunction

	// access class of an entry, none when it does not exist here
	function automatic encoder_od_pkg::access_t entry_access(input logic [15:0] idx,
		input logic [7:0] sub);
		entry_access = encoder_od_pkg::ACC_NONE;
		if ((idx == encoder_od_pkg::IDX_OPERATING_TIME ||
			idx == encoder_od_pkg::IDX_PRESET_OFFSET_VALUE ||
			idx == encoder_od_pkg::IDX_SERIAL_NUMBER) && sub == encoder_od_pkg::SUB_ZERO) begin
			entry_access = encoder_od_pkg::ACC_RO;
		end else if (idx == encoder_od_pkg::IDX_MODULE_POSITION_LIMITS &&
			sub <= encoder_od_pkg::SUB_MFR_MAX) begin
			entry_access = encoder_od_pkg::ACC_RO;
		end else if (idx == encoder_od_pkg::IDX_IDENTITY &&
			sub == encoder_od_pkg::SUB_IDENTITY_SERIAL) begin
			entry_access = encoder_od_pkg::ACC_RO;
		end
	endfunction

	function automatic logic index_known(input logic [15:0] idx);
		index_known = (idx == encoder_od_pkg::IDX_OPERATING_TIME) ||
			(idx == encoder_od_pkg::IDX_PRESET_OFFSET_VALUE) ||
			(idx == encoder_od_pkg::IDX_MODULE_POSITION_LIMITS) ||
			(idx == encoder_od_pkg::IDX_SERIAL_NUMBER) ||
			(idx == encoder_od_pkg::IDX_IDENTITY);
	endfunction

	logic [6:0] node_sync;
	logic [3:0] baud_sync;
	logic [6:0] node_cur;
	logic [3:0] baud_cur;
	logic settings_applied;
	logic apply_settings;

	pin_sync #(
		.WIDTH(7)
	) u_node_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(node_switch_pins),
		.pin_out(node_sync)
	);

	pin_sync #(
		.WIDTH(4)
	) u_baud_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(baud_switch_pins),
		.pin_out(baud_sync)
	);

	assign apply_settings = nmt_reset_cmd || store_params_cmd;

	settings_latch u_settings (
		.clk_sys(clk_sys),
		.rst(rst),
		.node_sel_in(node_sync),
		.baud_sel_in(baud_sync),
		.apply(apply_settings),
		.node_number(node_cur),
		.baud_sel(baud_cur),
		.applied(settings_applied)
	);

	// stored entries and answer
	logic [31:0] offset_reg;
	logic [31:0] offset_next;
	logic rsp_valid_reg;
	logic rsp_valid_next;
	logic [31:0] rsp_data_reg;
	logic [31:0] rsp_data_next;
	logic rsp_abort_reg;
	logic rsp_abort_next;
	logic [31:0] rsp_code_reg;
	logic [31:0] rsp_code_next;
	logic [10:0] rsp_cob_reg;
	logic [10:0] rsp_cob_next;
	encoder_od_pkg::access_t acc;

	always_comb begin
		offset_next = offset_reg;
		if (preset_offset_load) begin
			offset_next = preset_offset_in;
		end
		acc = entry_access(sdo_req_index, sdo_req_subindex);
		rsp_valid_next = sdo_req_valid;
		rsp_data_next = 32'h0000_0000;
		rsp_abort_next = 1'b0;
		rsp_code_next = encoder_od_pkg::ABORT_NONE;
		rsp_cob_next = cob_id(encoder_od_pkg::FC_SDO_TX, node_cur);
		if (sdo_req_valid) begin
			if (acc == encoder_od_pkg::ACC_NONE) begin
				rsp_abort_next = 1'b1;
				if (index_known(sdo_req_index)) begin
					rsp_code_next = encoder_od_pkg::ABORT_NO_SUBINDEX;
				end else begin
					rsp_code_next = encoder_od_pkg::ABORT_NO_OBJECT;
				end
			end else if (sdo_req_write && acc == encoder_od_pkg::ACC_RO) begin
				rsp_abort_next = 1'b1;
				rsp_code_next = encoder_od_pkg::ABORT_WRITE_READ_ONLY;
			end else if (!sdo_req_write && acc == encoder_od_pkg::ACC_WO) begin
				rsp_abort_next = 1'b1;
				rsp_code_next = encoder_od_pkg::ABORT_READ_WRITE_ONLY;
			end else if (sdo_req_index == encoder_od_pkg::IDX_OPERATING_TIME) begin
				rsp_data_next = encoder_od_pkg::OPERATING_TIME_VALUE;
			end else if (sdo_req_index == encoder_od_pkg::IDX_PRESET_OFFSET_VALUE) begin
				rsp_data_next = offset_reg;
			end else if (sdo_req_index == encoder_od_pkg::IDX_MODULE_POSITION_LIMITS) begin
				if (sdo_req_subindex == encoder_od_pkg::SUB_ZERO) begin
					rsp_data_next = encoder_od_pkg::MODULE_HIGHEST_SUB;
				end else if (sdo_req_subindex == encoder_od_pkg::SUB_MFR_OFFSET) begin
					rsp_data_next = MFR_OFFSET;
				end else if (sdo_req_subindex == encoder_od_pkg::SUB_MFR_MIN) begin
					rsp_data_next = MFR_MIN_POSITION;
				end else begin
					rsp_data_next = MFR_MAX_POSITION;
				end
			end else begin
				rsp_data_next = SERIAL_NUMBER;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			offset_reg <= encoder_od_pkg::PRESET_OFFSET_RESET;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= 32'h0000_0000;
			rsp_abort_reg <= 1'b0;
			rsp_code_reg <= encoder_od_pkg::ABORT_NONE;
			rsp_cob_reg <= 11'h000;
		end else begin
			offset_reg <= offset_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
			rsp_abort_reg <= rsp_abort_next;
			rsp_code_reg <= rsp_code_next;
			rsp_cob_reg <= rsp_cob_next;
		end
	end

	// boot-up sequence
	boot_state_t boot_reg;
	boot_state_t boot_next;
	logic boot_req_reg;
	logic boot_req_next;
	logic [10:0] boot_cob_reg;
	logic [10:0] boot_cob_next;

	always_comb begin
		boot_next = boot_reg;
		boot_req_next = 1'b0;
		boot_cob_next = boot_cob_reg;
		case (boot_reg)
			BOOT_INIT: begin
				if (settings_applied) begin
					boot_next = BOOT_WAIT_RATE;
				end
			end
			BOOT_WAIT_RATE: begin
				if (bus_rate_ok) begin
					boot_next = BOOT_SEND;
					boot_req_next = 1'b1;
					boot_cob_next = cob_id(encoder_od_pkg::FC_BOOTUP, node_cur);
				end
			end
			BOOT_SEND: begin
				boot_req_next = 1'b1;
				if (bootup_tx_ack) begin
					boot_next = BOOT_RUN;
					boot_req_next = 1'b0;
				end
			end
			BOOT_RUN: begin
				boot_next = BOOT_RUN;
			end
			default: begin
				boot_next = BOOT_INIT;
			end
		endcase
		// a network reset restarts the whole sequence
		if (nmt_reset_cmd) begin
			boot_next = BOOT_INIT;
			boot_req_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boot_reg <= BOOT_INIT;
			boot_req_reg <= 1'b0;
			boot_cob_reg <= 11'h000;
		end else begin
			boot_reg <= boot_next;
			boot_req_reg <= boot_req_next;
			boot_cob_reg <= boot_cob_next;
		end
	end

	// limit switch gating
	logic limit_en_reg;
	logic limit_en_next;
	logic [1:0] limit_out_reg;
	logic [1:0] limit_out_next;
	logic [6:0] node_out_reg;
	logic [3:0] baud_out_reg;

	always_comb begin
		limit_en_next = limit_en_reg || limit_enable_cmd;
		limit_out_next = limit_en_reg ? limit_bits_in : 2'b00;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			limit_en_reg <= 1'b0;
			limit_out_reg <= 2'b00;
			node_out_reg <= encoder_od_pkg::NODE_NUMBER_RESET;
			baud_out_reg <= encoder_od_pkg::BAUD_SEL_RESET;
		end else begin
			limit_en_reg <= limit_en_next;
			limit_out_reg <= limit_out_next;
			node_out_reg <= node_cur;
			baud_out_reg <= baud_cur;
		end
	end

	assign sdo_rsp_valid = rsp_valid_reg;
	assign sdo_rsp_data = rsp_data_reg;
	assign sdo_rsp_abort = rsp_abort_reg;
	assign sdo_rsp_abort_code = rsp_code_reg;
	assign sdo_rsp_cob_id = rsp_cob_reg;
	assign bootup_tx_req = boot_req_reg;
	assign bootup_cob_id = boot_cob_reg;
	assign limit_bits_out = limit_out_reg;
	assign node_number = node_out_reg;
	assign baud_sel = baud_out_reg;

endmodule // encoder_od_diagnostic_objects

// File: encoder_od_diagnostic_objects_assertions.sv
// concurrent checks on the diagnostic entry bank ports
`timescale 1ns/1ps
module od_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sdo_req_valid,
	input wire logic sdo_req_write,
	input wire logic [15:0] sdo_req_index,
	input wire logic [7:0] sdo_req_subindex,
	input wire logic sdo_rsp_valid,
	input wire logic [31:0] sdo_rsp_data,
	input wire logic sdo_rsp_abort,
	input wire logic [31:0] sdo_rsp_abort_code,
	input wire logic [10:0] sdo_rsp_cob_id,
	input wire logic bootup_tx_req,
	input wire logic [10:0] bootup_cob_id,
	input wire logic bootup_tx_ack,
	input wire logic limit_enable_cmd,
	input wire logic [1:0] limit_bits_out,
	input wire logic [6:0] node_number
);
	logic lim_en_reg;
	logic lim_en_next;
	always_comb begin
		lim_en_next = lim_en_reg | limit_enable_cmd;
	end
	always_ff @(posedge clk_sys) begin
		lim_en_reg <= rst ? 1'b0 : lim_en_next;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_boot_wait;
		bootup_tx_req && !bootup_tx_ack;
	endsequence
	sequence s_boot_ack;
		bootup_tx_req && bootup_tx_ack;
	endsequence
	a_rsp_follows: assert property (sdo_req_valid |=> sdo_rsp_valid)
		else $error("answer missing after request");
	a_no_unasked: assert property (!sdo_req_valid |=> !sdo_rsp_valid && !sdo_rsp_abort)
		else $error("answer without request");
	a_optime_fixed: assert property (sdo_req_valid && !sdo_req_write
		&& sdo_req_index == 16'h6508 && sdo_req_subindex == 8'h00
		|=> sdo_rsp_data == 32'h0FFF_FFFF && !sdo_rsp_abort)
		else $error("operating time value wrong");
	a_write_refused: assert property (sdo_req_valid && sdo_req_write
		&& sdo_req_index inside {[16'h6508:16'h650B]} && sdo_req_subindex == 8'h00
		|=> sdo_rsp_abort && sdo_rsp_abort_code == 32'h0601_0002)
		else $error("write to read-only entry not refused");
	a_no_object: assert property (sdo_req_valid && sdo_req_index == 16'h6510
		|=> sdo_rsp_abort && sdo_rsp_abort_code == 32'h0602_0000)
		else $error("unknown entry not refused");
	a_rsp_cob: assert property (sdo_rsp_valid |-> sdo_rsp_cob_id == {4'hB, node_number})
		else $error("answer identifier wrong");
	a_boot_cob: assert property (bootup_tx_req && $past(bootup_tx_req)
		|-> bootup_cob_id == {4'hE, node_number})
		else $error("boot-up identifier wrong");
	a_boot_held: assert property (s_boot_wait |=> bootup_tx_req)
		else $error("boot-up request dropped before acknowledge");
	a_boot_drop: assert property (s_boot_ack |=> !bootup_tx_req)
		else $error("boot-up request repeated");
	a_limit_muted: assert property (!lim_en_reg |-> limit_bits_out == 2'b00)
		else $error("limit bits sent before activation");
endmodule // od_checker

// File: can_ctrl_model.sv
// far-side controller model: bit rate match and boot-up acknowledge
`timescale 1ns/1ps
module can_ctrl_model #(
	parameter int ACK_DELAY = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic bootup_tx_req,
	output logic bus_rate_ok,
	output logic bootup_tx_ack
);
	int cnt;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt <= 0;
			bus_rate_ok <= 1'b0;
			bootup_tx_ack <= 1'b0;
		end else begin
			bus_rate_ok <= 1'b1;
			cnt <= bootup_tx_req ? cnt + 1 : 0;
			bootup_tx_ack <= bootup_tx_req && (cnt == ACK_DELAY);
		end
	end
endmodule // can_ctrl_model

// File: tb_top.sv
// self-checking bench for the diagnostic entry bank
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] SER = 32'h1234_5678; // arbitrary serial number
	localparam logic [31:0] MOFS = 32'h0000_0010;
	localparam logic [31:0] MMIN = 32'hFFFF_F000;
	localparam logic [31:0] MMAX = 32'h0000_7FFF;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sdo_req_valid = 1'b0;
	logic sdo_req_write = 1'b0;
	logic [15:0] sdo_req_index = 16'h0000;
	logic [7:0] sdo_req_subindex = 8'h00;
	logic sdo_rsp_valid, sdo_rsp_abort, bootup_tx_req, bus_rate_ok, bootup_tx_ack;
	logic [31:0] sdo_rsp_data, sdo_rsp_abort_code;
	logic [10:0] sdo_rsp_cob_id, bootup_cob_id;
	logic preset_offset_load = 1'b0;
	logic [31:0] preset_offset_in = 32'h0000_0000;
	logic [6:0] node_switch_pins = 7'h05;
	logic [3:0] baud_switch_pins = 4'h3;
	logic nmt_reset_cmd = 1'b0;
	logic store_params_cmd = 1'b0;
	logic limit_enable_cmd = 1'b0;
	logic [1:0] limit_bits_in = 2'b00;
	logic [1:0] limit_bits_out;
	logic [6:0] node_number;
	logic [3:0] baud_sel;
	logic [6:0] exp_node = 7'h05;
	logic [31:0] lims [4] = '{encoder_od_pkg::MODULE_HIGHEST_SUB, MOFS, MMIN, MMAX};
	int err_count = 0;
	int total_checks = 0;
	encoder_od_diagnostic_objects #(.SERIAL_NUMBER(SER), .MFR_OFFSET(MOFS),
		.MFR_MIN_POSITION(MMIN), .MFR_MAX_POSITION(MMAX)) i_dut (
		.clk_sys(clk_sys), .rst(rst),
		.sdo_req_valid(sdo_req_valid), .sdo_req_write(sdo_req_write),
		.sdo_req_index(sdo_req_index), .sdo_req_subindex(sdo_req_subindex),
		.sdo_rsp_valid(sdo_rsp_valid), .sdo_rsp_data(sdo_rsp_data),
		.sdo_rsp_abort(sdo_rsp_abort), .sdo_rsp_abort_code(sdo_rsp_abort_code),
		.sdo_rsp_cob_id(sdo_rsp_cob_id), .preset_offset_load(preset_offset_load),
		.preset_offset_in(preset_offset_in), .node_switch_pins(node_switch_pins),
		.baud_switch_pins(baud_switch_pins), .nmt_reset_cmd(nmt_reset_cmd),
		.store_params_cmd(store_params_cmd), .bus_rate_ok(bus_rate_ok),
		.bootup_tx_req(bootup_tx_req), .bootup_cob_id(bootup_cob_id),
		.bootup_tx_ack(bootup_tx_ack), .limit_enable_cmd(limit_enable_cmd),
		.limit_bits_in(limit_bits_in), .limit_bits_out(limit_bits_out),
		.node_number(node_number), .baud_sel(baud_sel));
	can_ctrl_model #(.ACK_DELAY(4)) i_ctrl (.clk_sys(clk_sys), .rst(rst),
		.bootup_tx_req(bootup_tx_req), .bus_rate_ok(bus_rate_ok),
		.bootup_tx_ack(bootup_tx_ack));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic results();
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic sdo(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] exp_data, input logic [31:0] exp_code);
		@(negedge clk_sys);
		sdo_req_valid = 1'b1;
		sdo_req_write = wr;
		sdo_req_index = idx;
		sdo_req_subindex = sub;
		@(negedge clk_sys);
		sdo_req_valid = 1'b0;
		chk({31'h0, sdo_rsp_valid}, 32'h1);
		chk(sdo_rsp_data, exp_data);
		chk({31'h0, sdo_rsp_abort}, {31'h0, exp_code != 32'h0});
		chk(sdo_rsp_abort_code, exp_code);
		chk({21'h0, sdo_rsp_cob_id}, {21'h0, encoder_od_pkg::FC_SDO_TX, exp_node});
	endtask
	task automatic boot(input logic [6:0] nd);
		int n;
		n = 0;
		while (bootup_tx_req !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		chk({31'h0, bootup_tx_req}, 32'h1);
		chk({21'h0, bootup_cob_id}, {21'h0, encoder_od_pkg::FC_BOOTUP, nd});
		tick(10);
		chk({31'h0, bootup_tx_req}, 32'h0);
	endtask
	initial begin
		tick(12);
		rst = 1'b0;
		tick(3);
		chk({25'h0, node_number}, 32'h0000_0005);
		chk({28'h0, baud_sel}, 32'h0000_0003);
		boot(7'h05);
		sdo(1'b0, 16'h6508, 8'h00, 32'h0FFF_FFFF, 32'h0);
		sdo(1'b0, 16'h6509, 8'h00, 32'h0, 32'h0);
		preset_offset_in = 32'hFFFF_FF00;
		preset_offset_load = 1'b1;
		tick(1);
		preset_offset_load = 1'b0;
		sdo(1'b0, 16'h6509, 8'h00, 32'hFFFF_FF00, 32'h0);
		for (int i = 0; i < 4; i++) begin
			sdo(1'b0, 16'h650A, 8'(i), lims[i], 32'h0);
		end
		sdo(1'b0, 16'h650A, 8'h04, 32'h0, 32'h0609_0011);
		sdo(1'b0, 16'h650B, 8'h00, SER, 32'h0);
		sdo(1'b0, 16'h1018, 8'h04, SER, 32'h0);
		for (int i = 0; i < 4; i++) begin
			sdo(1'b1, 16'h6508 + 16'(i), 8'h00, 32'h0, 32'h0601_0002);
		end
		sdo(1'b1, 16'h1018, 8'h04, 32'h0, 32'h0601_0002);
		sdo(1'b0, 16'h1018, 8'h00, 32'h0, 32'h0609_0011);
		sdo(1'b0, 16'h6509, 8'h00, 32'hFFFF_FF00, 32'h0);
		sdo(1'b0, 16'h6510, 8'h00, 32'h0, 32'h0602_0000);
		node_switch_pins = 7'h09;
		baud_switch_pins = 4'h5;
		tick(5);
		chk({25'h0, node_number}, 32'h0000_0005);
		store_params_cmd = 1'b1;
		tick(1);
		store_params_cmd = 1'b0;
		tick(3);
		exp_node = 7'h09;
		chk({25'h0, node_number}, 32'h0000_0009);
		chk({28'h0, baud_sel}, 32'h0000_0005);
		chk({31'h0, bootup_tx_req}, 32'h0);
		sdo(1'b0, 16'h6508, 8'h00, 32'h0FFF_FFFF, 32'h0);
		node_switch_pins = 7'h0A;
		tick(3);
		nmt_reset_cmd = 1'b1;
		tick(1);
		nmt_reset_cmd = 1'b0;
		exp_node = 7'h0A;
		boot(7'h0A);
		limit_bits_in = 2'b11;
		tick(3);
		chk({30'h0, limit_bits_out}, 32'h0);
		limit_enable_cmd = 1'b1;
		tick(1);
		limit_enable_cmd = 1'b0;
		tick(3);
		chk({30'h0, limit_bits_out}, 32'h3);
		limit_bits_in = 2'b01;
		tick(2);
		chk({30'h0, limit_bits_out}, 32'h1);
		results();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		results();
	end
endmodule // tb_top
bind encoder_od_diagnostic_objects od_checker i_chk (.clk_sys(clk_sys), .rst(rst),
	.sdo_req_valid(sdo_req_valid), .sdo_req_write(sdo_req_write),
	.sdo_req_index(sdo_req_index), .sdo_req_subindex(sdo_req_subindex),
	.sdo_rsp_valid(sdo_rsp_valid), .sdo_rsp_data(sdo_rsp_data),
	.sdo_rsp_abort(sdo_rsp_abort), .sdo_rsp_abort_code(sdo_rsp_abort_code),
	.sdo_rsp_cob_id(sdo_rsp_cob_id), .bootup_tx_req(bootup_tx_req),
	.bootup_cob_id(bootup_cob_id), .bootup_tx_ack(bootup_tx_ack),
	.limit_enable_cmd(limit_enable_cmd), .limit_bits_out(limit_bits_out),
	.node_number(node_number));
